// file: rtl/phy_autoneg_registers.sv
/*
 * identifier-low, advertisement, link partner ability and expansion
 * registers of a 10/100 phy, reached as an axi4-lite slave.
 * assumes the negotiation engine drives an_status on clk, and that
 * speed_sel_pin is a static strap from outside the clock domain.
 */
// Operation
// - identifier bits 15:10 return fixed organisation identifier bits 19 to 24
// - identifier bits 9:4 return a fixed six-bit model number
// - identifier bits 3:0 return a fixed four-bit revision number
// - advertised next-page bit 15 is writable, resets 0, no next-page exchange
// - advertised remote-fault bit 13 is writable, resets 0
// - advertised pause field 11:10 is writable, resets 00
// - advertised 100base-t4 bit 9 is writable, resets 0
// - bits 8..5 advertise speeds; bit 7 resets 1, others from strap
// - selector bits 4:0 of advertisement and partner words read 00001
// - partner word is read-only, reports partner bits, resets to zero
// - partner acknowledge bit 14 always reads 0
// - expansion bit 4 latches high on a parallel detection fault
// - expansion bit 1 latches high when a page is received
// - expansion bit 2 reads 0, no local next-page ability
// - expansion bit 3 shows partner next-page ability, resets 0
// - expansion bit 0 shows partner auto-negotiation ability, resets 0
`timescale 1ns/10ps
`include "phy_an_consts.svh"

module phy_autoneg_registers (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // axi4-lite write address and data
  input  wire logic [7:0]             awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  // axi4-lite write response
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  // axi4-lite read
  input  wire logic [7:0]             araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  // negotiation engine and strap
  input  wire phy_an_pkg::an_status_t an_status,
  input  wire logic                   speed_sel_pin
);

  function automatic phy_an_pkg::reg_sel_t reg_sel(input logic [7:0] addr);
    phy_an_pkg::reg_sel_t s;
    s = phy_an_pkg::SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[7:2])
        `IDX_ID_LOW:  s = phy_an_pkg::SEL_ID;
        `IDX_ADVERT:  s = phy_an_pkg::SEL_ADV;
        `IDX_PARTNER: s = phy_an_pkg::SEL_LP;
        `IDX_EXPAND:  s = phy_an_pkg::SEL_EXP;
        default:      s = phy_an_pkg::SEL_NONE;
      endcase
    end
    return s;
  endfunction

  logic [7:0]  awaddr_q;
  logic        aw_hold_q;
  logic [15:0] wdata_q;
  logic [1:0]  wstrb_q;
  logic        w_hold_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [15:0] rdata_q;
  logic [15:0] adv_q;
  logic [15:0] lp_q;
  logic        pd_fault_q;
  logic        page_rx_q;
  logic [2:0]  strap_sync_q;
  logic [2:0]  strap_fill_q;
  logic        strap_done_q;
  logic        do_wr;
  logic        ar_take;
  logic        adv_wr;
  logic        exp_rd;
  logic        strap_load;
  logic [15:0] adv_mask;
  logic [15:0] id_word;
  logic [15:0] lp_word;
  logic [15:0] exp_word;

  // write channel: address and data are held separately, either order
  assign awready = ~aw_hold_q;
  assign wready  = ~w_hold_q;
  assign do_wr   = aw_hold_q & w_hold_q & ~bvalid_q;
  assign adv_wr  = do_wr & (reg_sel(awaddr_q) == phy_an_pkg::SEL_ADV);
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (awvalid && awready) begin
      aw_hold_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (do_wr) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_hold_q <= 1'b0;
      wdata_q  <= 16'h0000;
      wstrb_q  <= 2'h0;
    end else if (wvalid && wready) begin
      w_hold_q <= 1'b1;
      wdata_q  <= wdata[15:0];
      wstrb_q  <= wstrb[1:0];
    end else if (do_wr) begin
      w_hold_q <= 1'b0;
    end
  end

  // writes to read-only registers are accepted and ignored
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (reg_sel(awaddr_q) == phy_an_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // strap sampled after reset release; stages 2 and 3 must agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_sync_q <= 3'h0;
      strap_fill_q <= 3'h0;
    end else begin
      strap_sync_q <= {strap_sync_q[1:0], speed_sel_pin};
      strap_fill_q <= {strap_fill_q[1:0], 1'b1};
    end
  end

  // a strap that never settles leaves bits 8, 6 and 5 at their reset value
  assign strap_load = strap_fill_q[2] & ~strap_done_q
                    & (strap_sync_q[1] == strap_sync_q[2]);

  // a software write before the strap settles keeps the software value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_done_q <= 1'b0;
    end else if (strap_load || adv_wr) begin
      strap_done_q <= 1'b1;
    end
  end

  // selector bits sit outside the write mask and keep their reset value
  assign adv_mask = `ADV_WMASK & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      adv_q <= `ADV_RESET;
    end else if (adv_wr) begin
      adv_q <= (adv_q & ~adv_mask) | (wdata_q & adv_mask);
    end else if (strap_load) begin
      adv_q[`ADV_TXFD] <= strap_sync_q[2];
      adv_q[`ADV_10FD] <= strap_sync_q[2];
      adv_q[`ADV_10]   <= strap_sync_q[2];
    end
  end

  // partner word refreshes with each received page
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lp_q <= 16'h0000;
    end else if (an_status.page_rx) begin
      lp_q <= an_status.partner_word;
    end
  end

  // latched-high bits: a set in the clearing cycle wins
  assign ar_take = arvalid & arready;
  assign exp_rd  = ar_take & (reg_sel(araddr) == phy_an_pkg::SEL_EXP);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pd_fault_q <= 1'b0;
    end else begin
      pd_fault_q <= (pd_fault_q & ~exp_rd) | an_status.pd_fault;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_rx_q <= 1'b0;
    end else begin
      page_rx_q <= (page_rx_q & ~exp_rd) | an_status.page_rx;
    end
  end

  // read words
  assign id_word = {`ID_OUI_BITS, `ID_MODEL, `ID_REV};

  always_comb begin
    lp_word              = lp_q;
    lp_word[`LP_ACK]     = 1'b0;
    lp_word[4:0]         = `SELECTOR_8023;
  end

  always_comb begin
    exp_word            = 16'h0000;
    exp_word[`EXP_PDF]  = pd_fault_q;
    exp_word[`EXP_LPNP] = an_status.partner_np_able;
    exp_word[`EXP_NP]   = 1'b0;
    exp_word[`EXP_PR]   = page_rx_q;
    exp_word[`EXP_LPAN] = an_status.partner_an_able;
  end

  // read channel: one read under way, answer the edge after it is taken
  // a second read waits for rready; throughput traded for one data register
  assign arready = ~rvalid_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = {16'h0000, rdata_q};

  // data is captured at the address edge, before that edge clears the latches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= 16'h0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `RESP_OKAY;
      unique case (reg_sel(araddr))
        phy_an_pkg::SEL_ID:  rdata_q <= id_word;
        phy_an_pkg::SEL_ADV: rdata_q <= adv_q;
        phy_an_pkg::SEL_LP:  rdata_q <= lp_word;
        phy_an_pkg::SEL_EXP: rdata_q <= exp_word;
        default: begin
          rdata_q <= 16'h0000;
          rresp_q <= `RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_adv_write;
    adv_wr ##0 (wstrb_q == 2'h3);
  endsequence

  sequence s_read_id;
    ar_take ##0 (reg_sel(araddr) == phy_an_pkg::SEL_ID);
  endsequence

  sequence s_read_exp;
    exp_rd ##0 !an_status.pd_fault ##0 !an_status.page_rx;
  endsequence

  a_id_oui_bits: assert property (s_read_id |=> rdata[15:10] == `ID_OUI_BITS)
    else $error("identifier oui bits wrong");

  a_id_model_num: assert property (s_read_id |=> rdata[9:4] == `ID_MODEL)
    else $error("identifier model number wrong");

  a_id_rev_num: assert property (s_read_id |=> rdata[3:0] == `ID_REV)
    else $error("identifier revision wrong");

  a_adv_next_page: assert property (s_adv_write |=> adv_q[`ADV_NP] == $past(wdata_q[15]))
    else $error("next-page bit not written");

  a_adv_remote_fault: assert property (s_adv_write |=> adv_q[`ADV_RF] == $past(wdata_q[13]))
    else $error("remote-fault bit not written");

  a_adv_pause: assert property (s_adv_write |=> adv_q[11:10] == $past(wdata_q[11:10]))
    else $error("pause field not written");

  a_adv_t4_bit: assert property (s_adv_write |=> adv_q[`ADV_T4] == $past(wdata_q[9]))
    else $error("t4 bit not written");

  a_adv_speed_bits: assert property (s_adv_write |=> adv_q[8:5] == $past(wdata_q[8:5]))
    else $error("speed bits not written");

  a_strap_load: assert property (
    strap_load && !adv_wr |=> adv_q[`ADV_10] == $past(strap_sync_q[2]))
    else $error("strap not loaded into speed bits");

  a_selector_fixed: assert property (
    ar_take && reg_sel(araddr) inside {phy_an_pkg::SEL_ADV, phy_an_pkg::SEL_LP}
    |=> rdata[4:0] == `SELECTOR_8023)
    else $error("selector field not 00001");

  a_partner_capture: assert property (
    an_status.page_rx |=> lp_q == $past(an_status.partner_word))
    else $error("partner word not captured");

  a_partner_ack_zero: assert property (
    ar_take && reg_sel(araddr) == phy_an_pkg::SEL_LP |=> !rdata[`LP_ACK])
    else $error("acknowledge bit read as 1");

  a_pd_fault_latch: assert property (
    an_status.pd_fault |=> pd_fault_q [*1] ##1 (pd_fault_q || $past(exp_rd)))
    else $error("parallel fault not latched");

  a_page_rx_latch: assert property (an_status.page_rx |=> page_rx_q)
    else $error("page received not latched");

  a_local_np_zero: assert property (
    exp_rd |=> !rdata[`EXP_NP])
    else $error("local next-page ability not 0");

  a_partner_np_able: assert property (
    exp_rd |=> rdata[`EXP_LPNP] == $past(an_status.partner_np_able))
    else $error("partner next-page bit wrong");

  a_partner_an_able: assert property (
    exp_rd |=> rdata[`EXP_LPAN] == $past(an_status.partner_an_able))
    else $error("partner auto-negotiation bit wrong");

  a_read_clears: assert property (s_read_exp |=> !pd_fault_q && !page_rx_q)
    else $error("latched bits not cleared by read");

endmodule

// file: rtl/phy_an_consts.svh
/*
 * register indices, field positions, reset values and bus codes of the
 * auto-negotiation register bank.
 * assumes it is included by its bare name; definitions only.
 */
`ifndef PHY_AN_CONSTS_SVH
`define PHY_AN_CONSTS_SVH

// register indices; byte address is four times the index
`define IDX_ID_LOW      6'h03
`define IDX_ADVERT      6'h04
`define IDX_PARTNER     6'h05
`define IDX_EXPAND      6'h06

// identifier fields: arbitrary neutral values
`define ID_OUI_BITS     6'h2A
`define ID_MODEL        6'h15
`define ID_REV          4'h1

// advertisement word
`define ADV_RESET       16'h0081
`define ADV_WMASK       16'hBFE0
`define ADV_NP          15
`define ADV_RF          13
`define ADV_PAUSE_HI    11
`define ADV_PAUSE_LO    10
`define ADV_T4          9
`define ADV_TXFD        8
`define ADV_TX          7
`define ADV_10FD        6
`define ADV_10          5
`define SELECTOR_8023   5'h01

// partner word
`define LP_ACK          14

// expansion word
`define EXP_PDF         4
`define EXP_LPNP        3
`define EXP_NP          2
`define EXP_PR          1
`define EXP_LPAN        0

// bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// file: rtl/phy_an_pkg.sv
/*
 * types shared by the auto-negotiation register bank.
 * assumes nothing of its surroundings.
 */
package phy_an_pkg;

  typedef enum logic [2:0] {
    SEL_ID,
    SEL_ADV,
    SEL_LP,
    SEL_EXP,
    SEL_NONE
  } reg_sel_t;

  // results handed in by the negotiation engine, same clock
  typedef struct packed {
    logic [15:0] partner_word;
    logic        partner_an_able;
    logic        partner_np_able;
    logic        page_rx;
    logic        pd_fault;
  } an_status_t;

endpackage

// file: bench/tb_top.sv
/*
 * self-checking bench for the auto-negotiation register bank: axi4-lite
 * master tasks, a small integer model of the four registers, and the
 * negotiation engine's status inputs.
 * assumes the register bank and its package and header are compiled first.
 */
`timescale 1ns/10ps
`include "phy_an_consts.svh"

module tb_top;
  logic                   clk           = 1'b0;
  logic                   resetn        = 1'b0;
  logic [7:0]             awaddr        = 8'h00;
  logic                   awvalid       = 1'b0;
  logic [31:0]            wdata         = 32'h0000_0000;
  logic [3:0]             wstrb         = 4'h0;
  logic                   wvalid        = 1'b0;
  logic                   bready        = 1'b0;
  logic [7:0]             araddr        = 8'h00;
  logic                   arvalid       = 1'b0;
  logic                   rready        = 1'b0;
  phy_an_pkg::an_status_t an_status     = '0;
  logic                   speed_sel_pin = 1'b1;
  logic                   awready;
  logic                   wready;
  logic [1:0]             bresp;
  logic                   bvalid;
  logic                   arready;
  logic [31:0]            rdata;
  logic [1:0]             rresp;
  logic                   rvalid;
  int                     err_total     = 0;
  int                     checked       = 0;
  logic [15:0]            adv_m;
  logic [15:0]            lp_m;
  logic                   pr_m;
  logic                   pdf_m;

  always #5 clk = ~clk;

  phy_autoneg_registers dut (
    .clk           (clk),
    .resetn        (resetn),
    .awaddr        (awaddr),
    .awvalid       (awvalid),
    .awready       (awready),
    .wdata         (wdata),
    .wstrb         (wstrb),
    .wvalid        (wvalid),
    .wready        (wready),
    .bresp         (bresp),
    .bvalid        (bvalid),
    .bready        (bready),
    .araddr        (araddr),
    .arvalid       (arvalid),
    .arready       (arready),
    .rdata         (rdata),
    .rresp         (rresp),
    .rvalid        (rvalid),
    .rready        (rready),
    .an_status     (an_status),
    .speed_sel_pin (speed_sel_pin)
  );

  task summarize;
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task tmo(input int n);
    if (n > 200) begin
      err_total++;
      $display("[FAIL] bus answer expected within 200 cycles seen none");
      summarize();
    end
  endtask

  // the slave may take address and data on different edges; each is released alone
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] er);
    int n;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n <= 200; n++) begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    tmo(n);
    bready <= 1'b0;
    chk($sformatf("bresp at %h", a), {30'h0, er}, {30'h0, bresp});
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n <= 200; n++) begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    tmo(n);
    rready <= 1'b0;
    chk($sformatf("rdata at %h", a), ed, rdata);
    chk($sformatf("rresp at %h", a), {30'h0, er}, {30'h0, rresp});
  endtask

  // only bytes enabled by the strobes change, and only the writable bits in them
  task adv_wr(input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    m = 16'hbfe0 & {{8{s[1]}}, {8{s[0]}}};
    adv_m = (adv_m & ~m) | (d[15:0] & m);
    wr(8'h10, d, s, 2'h0);
  endtask

  // read shows the latched bits, then clears them; the fault bit stays set while the fault is still there
  task exp_rd;
    rd(8'h18, {27'h0, pdf_m, an_status.partner_np_able, 1'b0, pr_m,
               an_status.partner_an_able}, 2'h0);
    pr_m  = 1'b0;
    pdf_m = an_status.pd_fault;
  endtask

  task page(input logic [15:0] w);
    @(posedge clk);
    an_status.partner_word <= w;
    an_status.page_rx      <= 1'b1;
    @(posedge clk);
    an_status.page_rx <= 1'b0;
    lp_m = (w & 16'hbfe0) | 16'h0001;
    pr_m = 1'b1;
  endtask

  task do_reset(input logic strap);
    resetn        <= 1'b0;
    speed_sel_pin <= strap;
    an_status     <= '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("handshake after reset", 32'h0000_01c0,
        {23'h0, awready, wready, arready, bvalid, rvalid, bresp, rresp});
    chk("rdata after reset", 32'h0000_0000, rdata);
    adv_m = strap ? 16'h01e1 : 16'h0081;
    lp_m  = 16'h0001;
    pr_m  = 1'b0;
    pdf_m = 1'b0;
  endtask

  initial begin
    void'($urandom(32'hbdda));
    do_reset(1'b1);
    rd(8'h0c, {16'h0, `ID_OUI_BITS, `ID_MODEL, `ID_REV}, 2'h0);
    rd(8'h10, {16'h0, adv_m}, 2'h0);
    rd(8'h14, {16'h0, lp_m}, 2'h0);
    exp_rd();
    for (int p = 0; p < 4; p++) begin
      adv_wr(32'h0000_2081 | (p << 10), 4'h3);
      rd(8'h10, {16'h0, adv_m}, 2'h0);
    end
    repeat (12) begin
      adv_wr($urandom, 4'($urandom));
      rd(8'h10, {16'h0, adv_m}, 2'h0);
    end
    wr(8'h0c, 32'hffff_ffff, 4'hf, 2'h0);
    wr(8'h14, 32'hffff_ffff, 4'hf, 2'h0);
    wr(8'h18, 32'hffff_ffff, 4'hf, 2'h0);
    wr(8'h20, 32'hffff_ffff, 4'hf, 2'h2);
    wr(8'h12, 32'h0000_ffff, 4'hf, 2'h2);
    rd(8'h20, 32'h0000_0000, 2'h2);
    rd(8'h11, 32'h0000_0000, 2'h2);
    rd(8'h0c, {16'h0, `ID_OUI_BITS, `ID_MODEL, `ID_REV}, 2'h0);
    rd(8'h10, {16'h0, adv_m}, 2'h0);
    rd(8'h14, {16'h0, lp_m}, 2'h0);
    repeat (4) begin
      an_status.partner_an_able <= 1'($urandom);
      an_status.partner_np_able <= 1'($urandom);
      page(16'($urandom) | 16'h4000);
      rd(8'h14, {16'h0, lp_m}, 2'h0);
      exp_rd();
      exp_rd();
    end
    @(posedge clk);
    an_status.pd_fault <= 1'b1;
    @(posedge clk);
    an_status.pd_fault <= 1'b0;
    pdf_m = 1'b1;
    exp_rd();
    exp_rd();
    @(posedge clk);
    an_status.pd_fault <= 1'b1;
    @(posedge clk);
    pdf_m = 1'b1;
    exp_rd();
    exp_rd();
    @(posedge clk);
    an_status.pd_fault <= 1'b0;
    exp_rd();
    exp_rd();
    do_reset(1'b0);
    rd(8'h10, {16'h0, adv_m}, 2'h0);
    rd(8'h14, {16'h0, lp_m}, 2'h0);
    exp_rd();
    summarize();
  end
endmodule
